/* File: core/fsi_top.sv */
/*
  Fieldbus status indicators and IO protocol selection.
  Assumes link, reception and fault inputs come from other clock domains or pins;
  consumer status bytes arrive with a one-cycle strobe on clk.
*/
// What this block does
// R1: Network indicator blinks green with no connection or when the master reports stop.
// R2: Network indicator is solid green only while connected and the master reports run.
// R3: Consumer status byte 80h means run and 60h means stop.
// R4: Network and device indicators are off in reset; device is green when healthy, red on fault.
// R5: A port indicator is off on link-down, solid when up and blinks while receiving.
// R6: Each port indicator follows only its own port's traffic.
// R7: The installer uses the first port alone, or first toward master in a line.
// R8: The user network chains drives through at most two cascade stages.
// R9: Only 100 Mbps links count as up; 10 Mbps is not supported.
// R10: The IO-device protocol is enabled when any of four selections holds 34962.
// R11: Selection value 45238 in any setting wins and keeps the IO-device protocol off.
// R12: Selection changes are applied only at reset release.
// R13: All green blinking uses one fixed period from a prescaler.
`timescale 1ns/1ps
module fsi_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        fault,
  input  wire logic        connected,
  input  wire logic        iocs_valid,
  input  wire logic [7:0]  iocs,
  input  wire logic        first_port_link,
  input  wire logic        first_port_speed_100,
  input  wire logic        first_port_rx,
  input  wire logic        second_port_link,
  input  wire logic        second_port_speed_100,
  input  wire logic        second_port_rx,
  input  wire logic [15:0] eth_function_select_a,
  input  wire logic [15:0] eth_function_select_b,
  input  wire logic [15:0] eth_function_select_c,
  input  wire logic [15:0] eth_function_select_d,
  output logic             io_device_enable,
  output logic             tsn_priority,
  output logic             master_run,
  output logic             network_status_indicator,
  output logic             device_health_green,
  output logic             device_health_red,
  output logic             first_port_link_indicator,
  output logic             second_port_link_indicator
);
  localparam int unsigned NSYNC = 8;

  logic [1:0]       rst_sync;
  logic             rst_int_n;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] s1;
  logic [NSYNC-1:0] s2;
  logic [NSYNC-1:0] s3;
  logic [NSYNC-1:0] stable;
  logic             cfg_pending;
  logic             blink_phase;
  logic             f_fault;
  logic             f_conn;
  logic             f_l1;
  logic             f_s1;
  logic             f_r1;
  logic             f_l2;
  logic             f_s2;
  logic             f_r2;
  logic [15:0]      sel [fsi_pkg::SEL_COUNT];
  logic             any_io;
  logic             any_tsn;
  fsi_pkg::fsi_led_t health;

  // Reset release through two flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync[1];

  assign async_in = {fault, connected, first_port_link, first_port_speed_100,
                     first_port_rx, second_port_link, second_port_speed_100, second_port_rx};

  // Three-flop synchronisers; change accepted when stages two and three agree
  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      always_ff @(posedge clk or negedge rst_int_n) begin
        if (!rst_int_n) begin
          s1[i]     <= 1'b0;
          s2[i]     <= 1'b0;
          s3[i]     <= 1'b0;
          stable[i] <= 1'b0;
        end else begin
          s1[i] <= async_in[i];
          s2[i] <= s1[i];
          s3[i] <= s2[i];
          if (s2[i] == s3[i]) begin
            stable[i] <= s3[i];
          end
        end
      end
    end
  endgenerate

  assign f_fault = stable[7];
  assign f_conn  = stable[6];
  assign f_l1    = stable[5];
  assign f_s1    = stable[4];
  assign f_r1    = stable[3];
  assign f_l2    = stable[2];
  assign f_s2    = stable[1];
  assign f_r2    = stable[0];

  // Selection settings sampled once after reset release
  assign sel[0] = eth_function_select_a;
  assign sel[1] = eth_function_select_b;
  assign sel[2] = eth_function_select_c;
  assign sel[3] = eth_function_select_d;

  always_comb begin
    any_io  = 1'b0;
    any_tsn = 1'b0;
    for (int k = 0; k < fsi_pkg::SEL_COUNT; k++) begin
      if (sel[k] == fsi_pkg::SEL_IO_DEVICE) begin
        any_io = 1'b1; // [R10]
      end
      if (sel[k] == fsi_pkg::SEL_TSN_PRIORITY) begin
        any_tsn = 1'b1; // [R11]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      cfg_pending      <= 1'b1;
      io_device_enable <= 1'b0;
      tsn_priority     <= 1'b0;
    end else if (cfg_pending) begin
      cfg_pending      <= 1'b0; // [R12]
      io_device_enable <= any_io & ~any_tsn; // [R10] [R11]
      tsn_priority     <= any_tsn; // [R11]
    end
  end

  // Run or stop from the consumer status byte; other values keep the state
  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      master_run <= 1'b0;
    end else if (!f_conn || !io_device_enable) begin
      master_run <= 1'b0;
    end else if (iocs_valid && iocs == fsi_pkg::IOCS_RUN) begin
      master_run <= 1'b1; // [R3]
    end else if (iocs_valid && iocs == fsi_pkg::IOCS_STOP) begin
      master_run <= 1'b0; // [R3]
    end
  end

  fsi_blink u_blink (
    .clk   (clk),
    .rst_n (rst_int_n),
    .phase (blink_phase)
  );

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      network_status_indicator <= 1'b0; // [R4]
    end else if (f_conn && master_run) begin
      network_status_indicator <= 1'b1; // [R2]
    end else begin
      network_status_indicator <= blink_phase; // [R1] [R13]
    end
  end

  always_comb begin
    health = f_fault ? fsi_pkg::FSI_LED_RED : fsi_pkg::FSI_LED_GREEN; // [R4]
  end

  always_ff @(posedge clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      device_health_green <= 1'b0; // [R4]
      device_health_red   <= 1'b0;
    end else begin
      device_health_green <= (health == fsi_pkg::FSI_LED_GREEN);
      device_health_red   <= (health == fsi_pkg::FSI_LED_RED);
    end
  end

  // A 10 Mbps link is treated as down
  fsi_port_led u_led1 (
    .clk         (clk),
    .rst_n       (rst_int_n),
    .link_up     (f_l1 & f_s1), // [R9]
    .rx_active   (f_r1), // [R6]
    .blink_phase (blink_phase),
    .led_green   (first_port_link_indicator)
  );

  fsi_port_led u_led2 (
    .clk         (clk),
    .rst_n       (rst_int_n),
    .link_up     (f_l2 & f_s2), // [R9]
    .rx_active   (f_r2), // [R6]
    .blink_phase (blink_phase),
    .led_green   (second_port_link_indicator)
  );
endmodule : fsi_top

/* File: core/fsi_pkg.sv */
/*
  Constants for the fieldbus status indicator block.
  Assumes a 20 MHz system clock.
*/
package fsi_pkg;
  localparam int unsigned CLK_HZ           = 20000000;
  localparam int unsigned BLINK_HALF_MS    = 250;
  localparam int unsigned BLINK_HALF_CYC   = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned BLINK_CNT_W      = 23;
  localparam logic [7:0]  IOCS_RUN         = 8'h80;
  localparam logic [7:0]  IOCS_STOP        = 8'h60;
  localparam logic [15:0] SEL_IO_DEVICE    = 16'h8892;
  localparam logic [15:0] SEL_TSN_PRIORITY = 16'hb0b6;
  localparam int unsigned RX_HOLD_CYC      = 2000000;
  localparam int unsigned RX_HOLD_W        = 21;
  localparam int unsigned SEL_COUNT        = 4;

  typedef enum logic [1:0] {
    FSI_LED_OFF   = 2'b00,
    FSI_LED_GREEN = 2'b01,
    FSI_LED_RED   = 2'b10
  } fsi_led_t;
endpackage : fsi_pkg

/* File: core/fsi_blink.sv */
/*
  Blink prescaler: toggles a phase every half period of the blink.
  Assumes clk at 20 MHz and synchronous reset copy from the top.
*/
`timescale 1ns/1ps
module fsi_blink #(
  parameter int unsigned HALF_CYC = fsi_pkg::BLINK_HALF_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      phase
);
  logic [fsi_pkg::BLINK_CNT_W-1:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      phase <= 1'b0;
    end else if (count == fsi_pkg::BLINK_CNT_W'(HALF_CYC - 1)) begin // [R13]
      count <= '0;
      phase <= ~phase;
    end else begin
      count <= count + 1'b1;
    end
  end
endmodule : fsi_blink

/* File: core/fsi_port_led.sv */
/*
  One port link indicator: off when down, solid when up,
  blinking while reception was seen recently.
  Assumes link and reception inputs already synchronised.
*/
`timescale 1ns/1ps
module fsi_port_led #(
  parameter int unsigned HOLD_CYC = fsi_pkg::RX_HOLD_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic link_up,
  input  wire logic rx_active,
  input  wire logic blink_phase,
  output logic      led_green
);
  logic [fsi_pkg::RX_HOLD_W-1:0] hold;

  // Stretch short reception so the blink is visible
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold <= '0;
    end else if (!link_up) begin
      hold <= '0;
    end else if (rx_active) begin
      hold <= fsi_pkg::RX_HOLD_W'(HOLD_CYC);
    end else if (hold != '0) begin
      hold <= hold - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_green <= 1'b0;
    end else if (!link_up) begin
      led_green <= 1'b0; // [R5]
    end else if (hold != '0) begin
      led_green <= blink_phase; // [R5] [R6]
    end else begin
      led_green <= 1'b1; // [R5]
    end
  end
endmodule : fsi_port_led

/* File: verification/fsi_top_sva.sv */
/* Assertions on fsi_top ports. Assumes one clock and the bind below. */
`timescale 1ns/1ps
module fsi_top_sva (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       fault,
  input wire logic       iocs_valid,
  input wire logic [7:0] iocs,
  input wire logic       first_port_link,
  input wire logic       first_port_speed_100,
  input wire logic       io_device_enable,
  input wire logic       tsn_priority,
  input wire logic       master_run,
  input wire logic       network_status_indicator,
  input wire logic       device_health_green,
  input wire logic       device_health_red,
  input wire logic       first_port_link_indicator
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] up;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) up <= 3'h0;
    else if (up != 3'h7) up <= up + 3'h1;
  run_cause_a: assert property ($rose(master_run) |->
    $past(iocs_valid) && $past(iocs) == 8'h80) else $error("run without 80h");
  run_solid_a: assert property (master_run ##1 master_run |->
    network_status_indicator) else $error("run not solid");
  off_norun_a: assert property (!io_device_enable |-> !master_run)
    else $error("run while disabled");
  proto_excl_a: assert property (!(io_device_enable && tsn_priority))
    else $error("both protocols");
  sel_hold_a: assert property (up == 3'h7 |->
    $stable(io_device_enable) && $stable(tsn_priority)) else $error("selection moved");
  fault_red_a: assert property (fault[*8] |=> device_health_red)
    else $error("no red on fault");
  ok_green_a: assert property ((!fault)[*8] |=> device_health_green)
    else $error("no green");
  led_excl_a: assert property (!(device_health_green && device_health_red))
    else $error("red and green");
  link_off_a: assert property ((!first_port_link)[*8] |=> !first_port_link_indicator)
    else $error("led on link down");
  slow_off_a: assert property ((!first_port_speed_100)[*8] |=>
    !first_port_link_indicator) else $error("led on slow link");
endmodule : fsi_top_sva
bind fsi_top fsi_top_sva chk_i (.*);

/* File: verification/fsi_master_model.sv */
/* IO controller model. Assumes callers sit just after a falling edge. */
`timescale 1ns/1ps
module fsi_master_model (
  input  wire logic clk,
  output logic      connected,
  output logic      iocs_valid,
  output logic [7:0] iocs
);
  initial begin
    connected = 1'b0;
    iocs_valid = 1'b0;
    iocs = 8'h00;
  end
  // One status byte per packet; line scrambled when idle
  task automatic send(input logic [7:0] b, input logic last);
    iocs_valid = 1'b1;
    iocs = b;
    @(negedge clk);
    if (last) begin
      iocs_valid = 1'b0;
      iocs = ~b;
    end
  endtask : send
  task automatic link(input logic c);
    connected = c;
  endtask : link
endmodule : fsi_master_model

/* File: verification/fsi_top_tb.sv */
/* Bench for fsi_top. Assumes the master model and the bound checker. */
`timescale 1ns/1ps
module fsi_top_tb;
  logic        clk, rst_n, fault, l1, s1, r1, l2, s2, r2;
  logic [15:0] sa, sb, sc, sd;
  wire logic   conn, iv, en, tsn, run, ns, hg, hr, li1, li2;
  wire logic [7:0] ib;
  int          err_count, checks_done;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  fsi_master_model MST (.clk(clk), .connected(conn), .iocs_valid(iv), .iocs(ib));
  fsi_top DUT (.clk(clk), .rst_n(rst_n), .fault(fault), .connected(conn), .iocs_valid(iv),
    .iocs(ib), .first_port_link(l1), .first_port_speed_100(s1), .first_port_rx(r1),
    .second_port_link(l2), .second_port_speed_100(s2), .second_port_rx(r2),
    .eth_function_select_a(sa), .eth_function_select_b(sb), .eth_function_select_c(sc),
    .eth_function_select_d(sd), .io_device_enable(en), .tsn_priority(tsn),
    .master_run(run), .network_status_indicator(ns), .device_health_green(hg),
    .device_health_red(hr), .first_port_link_indicator(li1),
    .second_port_link_indicator(li2));
  // Short blink and reception hold so both fit in one run
  defparam DUT.u_blink.HALF_CYC = 4;
  defparam DUT.u_led1.HOLD_CYC = 8;
  defparam DUT.u_led2.HOLD_CYC = 8;
  task automatic chk(input logic got, input logic exp, input string m);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // Marks which of network, port 1, port 2 indicators changed in 8 cycles
  task automatic seen(output logic [2:0] tg);
    logic [2:0] first;
    first = {ns, li1, li2};
    tg = 3'h0;
    repeat (8) begin
      @(negedge clk);
      tg = tg | ({ns, li1, li2} ^ first);
    end
  endtask : seen
  task automatic boot(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
                      input logic [15:0] d);
    rst_n = 1'b0;
    {sa, sb, sc, sd} = {a, b, c, d};
    wt(5);
    rst_n = 1'b1;
    wt(8);
  endtask : boot
  task automatic t_select;
    boot(16'h270f, 16'h270f, 16'h270f, 16'h8892);
    chk(en, 1'b1, "io off");
    boot(16'h8892, 16'hb0b6, 16'h270f, 16'h270f);
    chk(en, 1'b0, "io on");
    chk(tsn, 1'b1, "tsn off");
    boot(16'h270f, 16'h1389, 16'h270f, 16'h270f);
    chk(en, 1'b0, "io on");
    chk(tsn, 1'b0, "tsn on");
    sa = 16'h8892;
    wt(8);
    chk(en, 1'b0, "early apply");
    boot(16'h8892, 16'h1389, 16'h270f, 16'h270f);
    chk(en, 1'b1, "not applied");
    $display("t_select done");
  endtask : t_select
  task automatic t_run;
    logic [2:0] tg;
    MST.link(1'b1);
    wt(8);
    MST.send(8'h80, 1'b1);
    wt(2);
    chk(run, 1'b1, "no run");
    chk(ns, 1'b1, "not solid");
    seen(tg);
    chk(tg[2], 1'b0, "run blinks");
    MST.send(8'h60, 1'b0);
    MST.send(8'h80, 1'b0);
    MST.send(8'h60, 1'b1);
    wt(2);
    chk(run, 1'b0, "no stop");
    seen(tg);
    chk(tg[2], 1'b1, "stop steady");
    MST.send(8'h80, 1'b0);
    MST.send(8'h55, 1'b1);
    wt(2);
    chk(run, 1'b1, "odd byte taken");
    MST.link(1'b0);
    wt(8);
    chk(run, 1'b0, "run unconnected");
    seen(tg);
    chk(tg[2], 1'b1, "idle steady");
    boot(16'h270f, 16'h270f, 16'h270f, 16'h270f);
    MST.link(1'b1);
    wt(8);
    MST.send(8'h80, 1'b1);
    wt(2);
    chk(run, 1'b0, "run disabled");
    $display("t_run done");
  endtask : t_run
  task automatic t_health;
    fault = 1'b1;
    wt(10);
    chk(hr, 1'b1, "no red");
    chk(hg, 1'b0, "green on fault");
    fault = 1'b0;
    wt(10);
    chk(hg, 1'b1, "no green");
    chk(hr, 1'b0, "red");
    rst_n = 1'b0;
    wt(2);
    chk(hg | hr | ns, 1'b0, "lit in reset");
    boot(16'h8892, 16'h270f, 16'h270f, 16'h270f);
    $display("t_health done");
  endtask : t_health
  task automatic t_ports;
    logic [2:0] tg;
    {l1, s1, l2, s2} = 4'hf; // First port toward master, single stage
    wt(8);
    chk(li1, 1'b1, "p1 not solid");
    chk(li2, 1'b1, "p2 not solid");
    s1 = 1'b0;
    wt(8);
    chk(li1, 1'b0, "slow lit");
    {l1, s1} = 2'h1;
    wt(8);
    chk(li1, 1'b0, "down lit");
    l1 = 1'b1;
    r1 = 1'b1;
    wt(6);
    r1 = 1'b0;
    chk(li2, 1'b1, "p2 follows p1");
    seen(tg);
    chk(tg[1], 1'b1, "p1 not blinking");
    chk(tg[0], 1'b0, "p2 blinks");
    wt(8);
    seen(tg);
    chk(tg[1], 1'b0, "p1 still blinking");
    chk(li1, 1'b1, "p1 not back solid");
    r2 = 1'b1;
    wt(6);
    r2 = 1'b0;
    seen(tg);
    chk(tg[0], 1'b1, "p2 not blinking");
    chk(tg[1], 1'b0, "p1 follows p2");
    $display("t_ports done");
  endtask : t_ports
  initial begin
    {rst_n, fault, l1, s1, r1, l2, s2, r2} = 8'h00;
    {sa, sb, sc, sd} = {4{16'h270f}};
    err_count = 0;
    checks_done = 0;
    t_select;
    t_run;
    t_health;
    t_ports;
    summarize;
  end
endmodule : fsi_top_tb
